/* ppd_consts.svh */
// register indices, reset values and fixed codes of the parallel port dma channel
`ifndef PPD_CONSTS_SVH
`define PPD_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define PPD_IDX_ADDR 12'h000
`define PPD_IDX_COUNT 12'h001
`define PPD_IDX_STATUS 12'h008
`define PPD_IDX_SMASK 12'h00A
`define PPD_IDX_MODE 12'h00B
`define PPD_IDX_CLRBP 12'h00C
`define PPD_IDX_MCLR 12'h00D
`define PPD_IDX_CLRMASK 12'h00E
`define PPD_IDX_MASK 12'h00F
`define PPD_IDX_FIFOLIM 12'h010
`define PPD_IDX_IRQSTAT 12'h020
`define PPD_IDX_IRQMASK 12'h021
`define PPD_IDX_PAGELO 12'h087
`define PPD_IDX_PAGEHI 12'h487
`define PPD_IDX_HCOUNT 12'h401
`define PPD_IDX_INTLOG 12'h40A

// field positions
`define PPD_MODE_TYPE_LSB 2
`define PPD_SMASK_BIT 2
`define PPD_STAT_REQ_BIT 4

// reset values
`define PPD_RST_MASK 1'b1
`define PPD_RST_TC 1'b1
`define PPD_RST_TYPE 2'h1

// codes and fixed read values
`define PPD_TYPE_MEM2PORT 2'h1
`define PPD_CNT_TC 24'hFFFFFF
`define PPD_MASK_HIGH_BITS 3'h7
`define PPD_JUNK_BYTE 8'hA5
`define PPD_IRQ_TC 0
`define PPD_IRQ_BYTE 1
`define PPD_IRQ_NUM 2

`endif

/* ppd_pkg.sv */
// types and shared helpers of the parallel port dma channel
package ppd_pkg;

  typedef logic [11:0] ppd_idx_t;

  typedef enum logic [1:0] {
    PPD_IDLE,
    PPD_FETCH,
    PPD_PUT
  } ppd_state_e;

  // replace the byte picked by the byte pointer in a 16-bit word
  function automatic logic [15:0] ppd_put_byte(input logic [15:0] v, input logic hi, input logic [7:0] b);
    logic [15:0] r;
    r = v;
    if (hi) begin
      r[15:8] = b;
    end else begin
      r[7:0] = b;
    end
    return r;
  endfunction : ppd_put_byte

  // pick the byte addressed by the byte pointer
  function automatic logic [7:0] ppd_get_byte(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction : ppd_get_byte

endpackage : ppd_pkg

/* ppd_regbus.sv */
// avalon-mm slave front end with one wait cycle per access
`timescale 1ns/1ps
`include "ppd_consts.svh"
module ppd_regbus import ppd_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_readparity,
  output logic avs_waitrequest,
  input wire logic [7:0] rd_value,
  output logic wr_stb,
  output logic rd_stb,
  output ppd_idx_t idx,
  output logic [7:0] wdata
);
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic next_readparity;
  logic req;

  // handshake and access strobes; side effects happen on the accept edge
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wr_stb = avs_write & ack & avs_byteenable[0];
  assign rd_stb = avs_read & ack;
  assign idx = avs_address;
  assign wdata = avs_writedata[7:0];

  // capture read data in the wait cycle so it stands at the accept edge
  always_comb begin
    next_ack = req & ~ack;
    next_readdata = avs_readdata;
    next_readparity = avs_readparity;
    if (avs_read & ~ack) begin
      next_readdata = {24'h000000, rd_value};
      next_readparity = ^rd_value; // even parity, junk reads included
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_readparity <= 1'b0;
    end else begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
      avs_readparity <= next_readparity;
    end
  end
endmodule : ppd_regbus

/* ppd_irq.sv */
// sticky interrupt status with mask and one level output
`timescale 1ns/1ps
module ppd_irq #(
  parameter int NUM = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NUM-1:0] event_set,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [NUM-1:0] wdata,
  output logic [NUM-1:0] status,
  output logic [NUM-1:0] mask,
  output logic irq
);
  logic [NUM-1:0] next_status;
  logic [NUM-1:0] next_mask;

  // write one to clear; a new event in the same cycle wins
  always_comb begin
    next_status = status;
    next_mask = mask;
    if (wr_status) begin
      next_status = status & ~wdata;
    end
    next_status = next_status | event_set;
    if (wr_mask) begin
      next_mask = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
      mask <= '0;
    end else begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  assign irq = |(status & mask);
endmodule : ppd_irq

/* ppd_channel.sv */
// parallel port dma channel: registers, byte pointer and memory-to-port engine
`timescale 1ns/1ps
`include "ppd_consts.svh"
module ppd_channel import ppd_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_readparity,
  output logic avs_waitrequest,
  output logic mem_rd_req,
  output logic [31:0] mem_addr,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_data,
  input wire logic port_req,
  input wire logic port_dma_en,
  output logic [7:0] port_data,
  output logic port_data_valid,
  output logic dma_busy,
  output logic irq
);
  logic wr_stb;
  logic rd_stb;
  ppd_idx_t idx;
  logic [7:0] wd;
  logic [7:0] rd_value;

  // programming state
  logic [15:0] addr_lo;
  logic [7:0] page_lo;
  logic [7:0] page_hi;
  logic [15:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic bp;
  logic chan_mask;
  logic [1:0] xfer_type;
  logic tc_flag;
  logic [15:0] next_addr_lo;
  logic [7:0] next_page_lo;
  logic [7:0] next_page_hi;
  logic [15:0] next_cnt_lo;
  logic [7:0] next_cnt_hi;
  logic next_bp;
  logic next_chan_mask;
  logic [1:0] next_xfer_type;
  logic next_tc_flag;

  // engine state
  ppd_state_e state;
  ppd_state_e next_state;
  logic [7:0] next_port_data;
  logic next_port_data_valid;

  // interrupt block
  logic [`PPD_IRQ_NUM-1:0] irq_events;
  logic [`PPD_IRQ_NUM-1:0] irq_status;
  logic [`PPD_IRQ_NUM-1:0] irq_mask;
  logic tc_event;

  logic [31:0] cur_addr;
  logic [31:0] inc_addr;
  logic [23:0] cur_cnt;
  logic [23:0] dec_cnt;
  logic xfer_on;
  logic start_ok;
  logic irq_stat_wr;
  logic irq_mask_wr;
  logic next_dma_busy;

  // true for the two ports reached through the byte pointer
  function automatic logic ptr_port(input ppd_idx_t i);
    return i == `PPD_IDX_ADDR || i == `PPD_IDX_COUNT;
  endfunction : ptr_port

  ppd_regbus u_regbus (
    .clk(clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_readparity(avs_readparity),
    .avs_waitrequest(avs_waitrequest),
    .rd_value(rd_value),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .idx(idx),
    .wdata(wd)
  );

  // write strobes of the two interrupt registers
  assign irq_stat_wr = wr_stb && idx == `PPD_IDX_IRQSTAT;
  assign irq_mask_wr = wr_stb && idx == `PPD_IDX_IRQMASK;

  ppd_irq #(
    .NUM(`PPD_IRQ_NUM)
  ) u_irq (
    .clk(clk),
    .rst_b(rst_b),
    .event_set(irq_events),
    .wr_status(irq_stat_wr),
    .wr_mask(irq_mask_wr),
    .wdata(wd[`PPD_IRQ_NUM-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // combined address and count views and their transfer steps
  assign cur_addr = {page_hi, page_lo, addr_lo};
  assign inc_addr = cur_addr + 32'h00000001;
  assign cur_cnt = {cnt_hi, cnt_lo};
  assign dec_cnt = cur_cnt - 24'h000001;
  assign xfer_on = !chan_mask && xfer_type == `PPD_TYPE_MEM2PORT;
  assign tc_event = (state == PPD_FETCH) && mem_rd_ack && dec_cnt == `PPD_CNT_TC;
  assign irq_events = {(state == PPD_PUT), tc_event};
  assign mem_addr = cur_addr;
  assign mem_rd_req = (state == PPD_FETCH);
  assign start_ok = xfer_on && port_dma_en && port_req;

  // read mux; unmapped and unimplemented locations give a junk byte
  always_comb begin
    if (idx == `PPD_IDX_ADDR) begin
      rd_value = ppd_get_byte(addr_lo, bp); // current address
    end else if (idx == `PPD_IDX_COUNT) begin
      rd_value = ppd_get_byte(cnt_lo, bp);
    end else if (idx == `PPD_IDX_PAGELO) begin
      rd_value = page_lo;
    end else if (idx == `PPD_IDX_PAGEHI) begin
      rd_value = page_hi;
    end else if (idx == `PPD_IDX_HCOUNT) begin
      rd_value = cnt_hi;
    end else if (idx == `PPD_IDX_STATUS) begin
      rd_value = {3'h0, port_req, 3'h0, tc_flag};
    end else if (idx == `PPD_IDX_MODE) begin
      rd_value = {4'h0, xfer_type, 1'b0, tc_flag};
    end else if (idx == `PPD_IDX_MASK) begin
      rd_value = {4'h0, `PPD_MASK_HIGH_BITS, chan_mask}; // channel zero alone
    end else if (idx == `PPD_IDX_IRQSTAT) begin
      rd_value = {6'h00, irq_status};
    end else if (idx == `PPD_IDX_IRQMASK) begin
      rd_value = {6'h00, irq_mask};
    end else begin
      rd_value = `PPD_JUNK_BYTE; // fifo limit lands here too
    end
  end

  // host register writes, then engine updates
  always_comb begin
    next_addr_lo = addr_lo;
    next_page_lo = page_lo;
    next_page_hi = page_hi;
    next_cnt_lo = cnt_lo;
    next_cnt_hi = cnt_hi;
    next_bp = bp;
    next_chan_mask = chan_mask;
    next_xfer_type = xfer_type;
    next_tc_flag = tc_flag;
    if (rd_stb && ptr_port(idx)) begin
      next_bp = ~bp;
    end
    if (wr_stb) begin
      if (idx == `PPD_IDX_ADDR) begin
        next_addr_lo = ppd_put_byte(addr_lo, bp, wd); // current address load, page bytes kept
        next_bp = ~bp;
      end else if (idx == `PPD_IDX_COUNT) begin
        next_cnt_lo = ppd_put_byte(cnt_lo, bp, wd);
        next_bp = ~bp;
      end else if (idx == `PPD_IDX_PAGELO) begin
        next_page_lo = wd;
      end else if (idx == `PPD_IDX_PAGEHI) begin
        next_page_hi = wd;
      end else if (idx == `PPD_IDX_HCOUNT) begin
        next_cnt_hi = wd;
      end else if (idx == `PPD_IDX_SMASK) begin
        if (wd[1:0] == 2'h0) begin
          next_chan_mask = wd[`PPD_SMASK_BIT];
        end
      end else if (idx == `PPD_IDX_MODE) begin
        if (wd[1:0] == 2'h0) begin
          next_xfer_type = wd[`PPD_MODE_TYPE_LSB +: 2];
        end
      end else if (idx == `PPD_IDX_CLRBP) begin
        next_bp = 1'b0;
      end else if (idx == `PPD_IDX_MCLR) begin
        next_bp = 1'b0;
        next_chan_mask = 1'b1;
        next_tc_flag = 1'b0;
      end else if (idx == `PPD_IDX_CLRMASK) begin
        next_chan_mask = 1'b0;
      end else if (idx == `PPD_IDX_MASK) begin
        next_chan_mask = wd[0];
      end
      if (next_chan_mask == 1'b0 && chan_mask == 1'b1) begin
        next_tc_flag = 1'b0; // unmasking arms a fresh transfer, no autoinit
      end
    end
    // a host write to address or count in an ack cycle is lost to the transfer
    // each fetched byte advances address and count
    if (state == PPD_FETCH && mem_rd_ack) begin
      next_addr_lo = inc_addr[15:0];
      next_page_lo = inc_addr[23:16];
      next_page_hi = inc_addr[31:24];
      next_cnt_lo = dec_cnt[15:0];
      next_cnt_hi = dec_cnt[23:16];
    end
    if (tc_event) begin
      next_tc_flag = 1'b1; // set wins over clear
      next_chan_mask = 1'b1; // channel stops until reprogrammed
    end
  end

  // engine: fetch a byte from memory, hand it to the port
  // a mask set during a fetch lets that byte finish; no new start follows
  always_comb begin
    next_state = state;
    next_port_data = port_data;
    next_port_data_valid = 1'b0;
    case (state)
      PPD_IDLE: begin
        if (start_ok) begin
          next_state = PPD_FETCH; // waits for port enable
        end
      end
      PPD_FETCH: begin
        if (mem_rd_ack) begin
          next_port_data = mem_rd_data; // memory read, port write
          next_port_data_valid = 1'b1;
          next_state = PPD_PUT;
        end
      end
      PPD_PUT: begin
        next_state = PPD_IDLE;
      end
      default: begin
        next_state = PPD_IDLE;
      end
    endcase
    // busy is registered so the pin does not glitch with the state decode
    next_dma_busy = (next_state != PPD_IDLE);
  end

  // programming registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_lo <= 16'h0000;
      page_lo <= 8'h00;
      page_hi <= 8'h00;
      cnt_lo <= 16'h0000;
      cnt_hi <= 8'h00;
      bp <= 1'b0;
      chan_mask <= `PPD_RST_MASK;
      xfer_type <= `PPD_RST_TYPE;
      tc_flag <= `PPD_RST_TC;
    end else begin
      addr_lo <= next_addr_lo;
      page_lo <= next_page_lo;
      page_hi <= next_page_hi;
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
      bp <= next_bp;
      chan_mask <= next_chan_mask;
      xfer_type <= next_xfer_type;
      tc_flag <= next_tc_flag;
    end
  end

  // engine registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PPD_IDLE;
      port_data <= 8'h00;
      port_data_valid <= 1'b0;
      dma_busy <= 1'b0;
    end else begin
      state <= next_state;
      port_data <= next_port_data;
      port_data_valid <= next_port_data_valid;
      dma_busy <= next_dma_busy;
    end
  end
endmodule : ppd_channel

/* ppd_channel_checker.sv */
// port assertions of the parallel port dma channel
`timescale 1ns/1ps
module ppd_channel_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_readparity,
  input wire logic avs_waitrequest,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_data,
  input wire logic port_req,
  input wire logic port_dma_en,
  input wire logic [7:0] port_data,
  input wire logic port_data_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rq = avs_read | avs_write;
  wire take = mem_rd_req & mem_rd_ack;
  // bus answer after exactly one wait cycle
  a_wait_first: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  a_wait_idle: assert property (!rq |-> !avs_waitrequest)
    else $error("waitrequest without request");
  // read byte carries even parity, upper bits zero
  a_read_par: assert property (avs_read && !avs_waitrequest |->
    avs_readparity == ^avs_readdata[7:0] && avs_readdata[31:8] == 24'h0)
    else $error("bad read parity or width");
  // fetched byte goes to the port next cycle
  a_byte_out: assert property (take |=> port_data_valid && port_data == $past(mem_rd_data))
    else $error("fetched byte not delivered");
  a_addr_step: assert property (take |=> mem_addr == $past(mem_addr) + 32'h1)
    else $error("address did not advance");
  a_valid_one: assert property (port_data_valid |=> !port_data_valid)
    else $error("valid longer than one cycle");
  a_start_cond: assert property ($rose(mem_rd_req) |-> $past(port_req && port_dma_en))
    else $error("fetch without enabled request");
  a_req_hold: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_addr))
    else $error("fetch dropped before answer");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_fetch: cover property ($rose(mem_rd_req));
  c_byte: cover property (port_data_valid);
endmodule : ppd_channel_checker

bind ppd_channel ppd_channel_checker u_ppd_channel_checker (.clk(clk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_readparity(avs_readparity), .avs_waitrequest(avs_waitrequest), .mem_rd_req(mem_rd_req),
  .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .port_req(port_req),
  .port_dma_en(port_dma_en), .port_data(port_data), .port_data_valid(port_data_valid));

/* ppd_partner.sv */
// memory and printer port model facing the dma channel
`timescale 1ns/1ps
module ppd_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] lat,
  input wire logic want,
  input wire logic port_data_valid,
  output logic mem_rd_ack,
  output logic [7:0] mem_rd_data,
  output logic port_req
);
  logic [1:0] wt;
  logic [1:0] gap;
  logic [7:0] b;
  // memory byte; inverted outside the answer cycle
  assign b = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3C;
  assign mem_rd_data = mem_rd_ack ? b : ~b;
  // memory answers a fetch after lat plus one wait cycles, one-cycle ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wt <= 2'h0;
      mem_rd_ack <= 1'b0;
    end else begin
      mem_rd_ack <= mem_rd_req && !mem_rd_ack && wt == lat;
      wt <= (mem_rd_req && !mem_rd_ack) ? wt + 2'h1 : 2'h0;
    end
  end
  // port drops its request after each byte, asks again later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 2'h0;
      port_req <= 1'b0;
    end else if (port_data_valid) begin
      gap <= 2'h3;
      port_req <= 1'b0;
    end else if (gap != 2'h0) begin
      gap <= gap - 2'h1;
    end else begin
      port_req <= want;
    end
  end
endmodule : ppd_partner

/* ppd_channel_bench.sv */
// self-checking bench of the parallel port dma channel
`timescale 1ns/1ps
`include "ppd_consts.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module ppd_channel_bench;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, avs_readparity, mem_rd_req, mem_rd_ack;
  logic port_req, port_dma_en, port_data_valid, dma_busy, irq, want;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, mem_addr, a;
  logic [3:0] avs_byteenable;
  logic [7:0] mem_rd_data, port_data, e;
  logic [1:0] lat;
  logic [7:0] exp_rd[$], exp_pt[$];
  int errors, samples_checked, i, t;

  ppd_channel u_ppd_channel (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_readparity(avs_readparity), .avs_waitrequest(avs_waitrequest),
    .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
    .port_req(port_req), .port_dma_en(port_dma_en), .port_data(port_data),
    .port_data_valid(port_data_valid), .dma_busy(dma_busy), .irq(irq));
  ppd_partner u_ppd_partner (.clk(clk), .rst_b(rst_b), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
    .lat(lat), .want(want), .port_data_valid(port_data_valid), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .port_req(port_req));

  function automatic logic [7:0] pat(input logic [31:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3C;
  endfunction : pat

  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] ad, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      final_report();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    bus(1'b1, ad, d);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [7:0] x);
    exp_rd.push_back(x);
    bus(1'b0, ad, 8'h00);
  endtask : rd

  task automatic idle_chk(input logic x);
    repeat (10) @(posedge clk);
    `CHK("dma_busy", 1'b0, dma_busy)
    `CHK("irq", x, irq)
  endtask : idle_chk

  // compare read data and port bytes against the oldest notes
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      e = exp_rd.pop_front();
      `CHK("readdata", e, avs_readdata[7:0])
    end
    if (port_data_valid) begin
      e = exp_pt.pop_front();
      `CHK("port_data", e, port_data)
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    port_dma_en = 1'b0;
    want = 1'b0;
    lat = 2'h0;
    errors = 0;
    samples_checked = 0;
    void'($urandom(32'hEDC7C7FF));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // reset values and unsupported places
    rd(`PPD_IDX_STATUS, 8'h01);
    rd(`PPD_IDX_MASK, 8'h0F);
    rd(`PPD_IDX_FIFOLIM, `PPD_JUNK_BYTE);
    rd(12'h123, `PPD_JUNK_BYTE);
    // every transfer type reads back; writes with low bits set refused
    for (t = 0; t < 4; t++) begin
      wr(`PPD_IDX_MODE, 8'(t << 2));
      rd(`PPD_IDX_MODE, 8'(t << 2) | 8'h01);
    end
    wr(`PPD_IDX_MODE, 8'h07);
    rd(`PPD_IDX_MODE, 8'h0D);
    // disabled type never starts
    port_dma_en <= 1'b1;
    want <= 1'b1;
    wr(`PPD_IDX_CLRMASK, 8'h00);
    for (t = 0; t < 4; t++) begin
      if (t != 1) begin
        wr(`PPD_IDX_MODE, 8'(t << 2));
        idle_chk(1'b0);
      end
    end
    port_dma_en <= 1'b0;
    wr(`PPD_IDX_SMASK, 8'h04);
    wr(`PPD_IDX_MODE, 8'h04);
    // program address and a three-byte count through the byte pointer
    a = $urandom;
    wr(`PPD_IDX_CLRBP, 8'h00);
    wr(`PPD_IDX_ADDR, a[7:0]);
    wr(`PPD_IDX_ADDR, a[15:8]);
    wr(`PPD_IDX_PAGELO, a[23:16]);
    wr(`PPD_IDX_PAGEHI, a[31:24]);
    wr(`PPD_IDX_COUNT, 8'h02);
    wr(`PPD_IDX_COUNT, 8'h00);
    wr(`PPD_IDX_HCOUNT, 8'h00);
    rd(`PPD_IDX_ADDR, a[7:0]);
    rd(`PPD_IDX_ADDR, a[15:8]);
    wr(`PPD_IDX_ADDR, 8'h5A);
    rd(`PPD_IDX_ADDR, a[15:8]);
    rd(`PPD_IDX_ADDR, 8'h5A);
    a[7:0] = 8'h5A;
    avs_byteenable <= 4'h0;
    wr(`PPD_IDX_PAGELO, ~a[23:16]);
    avs_byteenable <= 4'h1;
    rd(`PPD_IDX_PAGELO, a[23:16]);
    // waits for the port enable, then moves three bytes
    wr(`PPD_IDX_IRQMASK, 8'h03);
    wr(`PPD_IDX_CLRMASK, 8'h00);
    idle_chk(1'b0);
    for (i = 0; i < 3; i++) exp_pt.push_back(pat(a + i));
    port_dma_en <= 1'b1;
    for (i = 0; i < 300 && exp_pt.size() != 0; i++) begin
      @(posedge clk);
      lat <= 2'($urandom);
    end
    `CHK("bytes_left", 0, exp_pt.size())
    if (exp_pt.size() != 0) final_report();
    want <= 1'b0;
    idle_chk(1'b1);
    rd(`PPD_IDX_STATUS, 8'h01);
    rd(`PPD_IDX_MASK, 8'h0F);
    wr(`PPD_IDX_CLRBP, 8'h00);
    a = a + 32'h3;
    rd(`PPD_IDX_ADDR, a[7:0]);
    rd(`PPD_IDX_ADDR, a[15:8]);
    rd(`PPD_IDX_PAGELO, a[23:16]);
    rd(`PPD_IDX_COUNT, 8'hFF);
    rd(`PPD_IDX_COUNT, 8'hFF);
    rd(`PPD_IDX_HCOUNT, 8'hFF);
    // interrupt raised, masked and cleared
    rd(`PPD_IDX_IRQSTAT, 8'h03);
    wr(`PPD_IDX_IRQMASK, 8'h00);
    idle_chk(1'b0);
    wr(`PPD_IDX_IRQMASK, 8'h03);
    wr(`PPD_IDX_IRQSTAT, 8'h01);
    rd(`PPD_IDX_IRQSTAT, 8'h02);
    wr(`PPD_IDX_IRQSTAT, 8'h02);
    idle_chk(1'b0);
    // master clear sets the mask and rewinds the byte pointer
    wr(`PPD_IDX_CLRMASK, 8'h00);
    wr(`PPD_IDX_ADDR, 8'hC3);
    wr(`PPD_IDX_MCLR, 8'h99);
    rd(`PPD_IDX_MASK, 8'h0F);
    rd(`PPD_IDX_STATUS, 8'h00);
    rd(`PPD_IDX_ADDR, 8'hC3);
    rd(`PPD_IDX_MODE, 8'h04);
    want <= 1'b1;
    idle_chk(1'b0);
    // mid-run reset brings back the reset values
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`PPD_IDX_MODE, 8'h05);
    rd(`PPD_IDX_STATUS, 8'h11);
    rd(`PPD_IDX_MASK, 8'h0F);
    idle_chk(1'b0);
    final_report();
  end
endmodule : ppd_channel_bench
